// file: core/ivm_pkg.sv
// Constants and carrier types for the interrupt vector map.
// Assumes one core clock and the nested interrupt controller next to it.
// Behaviour
// - Enable, pend and active bank index equals interrupt number divided by 32.
// - Priority register index equals interrupt number divided by 4.
// - Software interrupt pends or clears only through pend-set and pend-clear writes.
// - Peripheral interrupt n uses vector n plus 16.
// - DMA channels k and k plus 16 completion share interrupt k.
// - Vector 14 is the pendable service request, outside the peripheral banks.
// - Vector 15 is the system tick exception, no peripheral interrupt number.
// - Any DMA channel 0 to 15 error raises interrupt 16, vector 32.
package ivm_pkg;

  // ==========================================================
  // Table geometry
  localparam logic [31:0] VEC_TABLE_BASE = 32'h0000_0000;
  localparam int VEC_ADDR_SHIFT = 2;
  localparam logic [7:0] IRQ_VEC_OFFSET = 8'h10;
  localparam int BANK_SHIFT = 5;
  localparam int PRIO_SHIFT = 2;

  // ==========================================================
  // Core exception vectors
  localparam logic [7:0] VEC_STACK_PTR = 8'h00;
  localparam logic [7:0] VEC_RESET_PC = 8'h01;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_USAGE = 8'h06;
  localparam logic [7:0] VEC_SUPERVISOR = 8'h0B;
  localparam logic [7:0] VEC_DEBUG_MON = 8'h0C;
  localparam logic [7:0] VEC_PEND_SERVICE = 8'h0E;
  localparam logic [7:0] VEC_SYS_TICK = 8'h0F;

  // ==========================================================
  // Interrupt sources handled here
  localparam int DMA_CHANNELS = 32;
  localparam int DMA_LINES = 16;
  localparam int IRQ_LINES = 17;
  localparam int DMA_ERR_IRQ = 16;
  localparam logic [7:0] SW_IRQ_NUM = 8'h5E;
  localparam logic [2:0] SW_IRQ_BANK = 3'h2;
  localparam int SW_IRQ_BIT = 30;

  // ==========================================================
  // Reset values
  localparam logic SW_PEND_RST = 1'b0;

  typedef enum logic [2:0] {
    IVM_RESERVED = 3'b000,
    IVM_STACK_PTR = 3'b001,
    IVM_RESET_PC = 3'b011,
    IVM_CORE_EXC = 3'b010,
    IVM_PERIPH = 3'b110
  } ivm_kind_t;

  // Answer to a vector lookup
  typedef struct packed {
    logic valid;
    ivm_kind_t kind;
    logic [7:0] vector;
    logic [31:0] tableAddr;
    logic [7:0] irqNum;
    logic [2:0] bankIdx;
    logic [4:0] bankBit;
    logic [5:0] prioIdx;
    logic [1:0] prioByte;
  } ivm_lookup_t;

  // Software write into the pend banks
  typedef struct packed {
    logic setWr;
    logic clrWr;
    logic [2:0] bankIdx;
    logic [31:0] data;
  } ivm_pend_wr_t;

endpackage

// file: core/ivm_vector_map.sv
// Interrupt vector map: combines DMA interrupt sources, tracks the software
// interrupt pend state, forwards core exceptions and answers vector lookups.
// Assumes all inputs synchronous to ref_clk; the controller consumes levels.
`timescale 1ns/10ps
`default_nettype none
module ivm_vector_map
  import ivm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [DMA_CHANNELS-1:0] dmaDoneIn,
  input wire logic [DMA_LINES-1:0] dmaErrIn,
  input wire logic pendServiceIn,
  input wire logic sysTickIn,
  input wire ivm_pend_wr_t pendWr,
  input wire logic lookupReq,
  input wire logic [7:0] lookupVec,
  output logic [IRQ_LINES-1:0] irqLine_r,
  output logic swPend_r,
  output logic pendServiceReq_r,
  output logic sysTickReq_r,
  output ivm_lookup_t lookup_r
);

  // ==========================================================
  // Peripheral interrupt lines
  logic [IRQ_LINES-1:0] irqLine_nxt;

  // Two DMA halves fold onto one line to keep the vector count down
  always_comb begin
    for (int k = 0; k < DMA_LINES; k++) begin
      irqLine_nxt[k] = dmaDoneIn[k] | dmaDoneIn[k+DMA_LINES];
    end
    irqLine_nxt[DMA_ERR_IRQ] = |dmaErrIn;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irqLine_r <= '0;
    end else begin
      irqLine_r <= irqLine_nxt;
    end
  end

  // ==========================================================
  // Software interrupt pend state
  logic swSetHit;
  logic swClrHit;
  logic swPend_nxt;

  assign swSetHit = pendWr.setWr && (pendWr.bankIdx == SW_IRQ_BANK) && pendWr.data[SW_IRQ_BIT];
  assign swClrHit = pendWr.clrWr && (pendWr.bankIdx == SW_IRQ_BANK) && pendWr.data[SW_IRQ_BIT];

  // Set wins so a pend written in the same cycle as a clear is not lost
  always_comb begin
    swPend_nxt = swPend_r;
    if (swSetHit) begin
      swPend_nxt = 1'b1;
    end else if (swClrHit) begin
      swPend_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      swPend_r <= SW_PEND_RST;
    end else begin
      swPend_r <= swPend_nxt;
    end
  end

  // ==========================================================
  // Core exceptions, never routed through the peripheral banks
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pendServiceReq_r <= 1'b0;
      sysTickReq_r <= 1'b0;
    end else begin
      pendServiceReq_r <= pendServiceIn;
      sysTickReq_r <= sysTickIn;
    end
  end

  // ==========================================================
  // Vector lookup
  ivm_lookup_t lookup_nxt;
  logic [7:0] irqOfVec;

  assign irqOfVec = lookupVec - IRQ_VEC_OFFSET;

  always_comb begin
    lookup_nxt = '0;
    lookup_nxt.valid = lookupReq;
    lookup_nxt.vector = lookupVec;
    lookup_nxt.tableAddr = VEC_TABLE_BASE + {22'h00_0000, lookupVec, 2'b00};
    if (lookupVec >= IRQ_VEC_OFFSET) begin
      lookup_nxt.kind = IVM_PERIPH;
      lookup_nxt.irqNum = irqOfVec;
      lookup_nxt.bankIdx = irqOfVec[7:BANK_SHIFT];
      lookup_nxt.bankBit = irqOfVec[BANK_SHIFT-1:0];
      lookup_nxt.prioIdx = irqOfVec[7:PRIO_SHIFT];
      lookup_nxt.prioByte = irqOfVec[PRIO_SHIFT-1:0];
    end else if (lookupVec == VEC_STACK_PTR) begin
      lookup_nxt.kind = IVM_STACK_PTR;
    end else if (lookupVec == VEC_RESET_PC) begin
      lookup_nxt.kind = IVM_RESET_PC;
    end else if ((lookupVec >= VEC_NMI) && (lookupVec <= VEC_USAGE)) begin
      lookup_nxt.kind = IVM_CORE_EXC;
    end else if ((lookupVec == VEC_SUPERVISOR) || (lookupVec == VEC_DEBUG_MON)) begin
      lookup_nxt.kind = IVM_CORE_EXC;
    end else if ((lookupVec == VEC_PEND_SERVICE) || (lookupVec == VEC_SYS_TICK)) begin
      // core slots carry no interrupt number
      lookup_nxt.kind = IVM_CORE_EXC;
    end else begin
      lookup_nxt.kind = IVM_RESERVED;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lookup_r <= '0;
    end else begin
      lookup_r <= lookup_nxt;
    end
  end

  // ==========================================================
  // Checks
  property p_bank_div;
    @(posedge ref_clk) disable iff (!nrst)
    (lookup_r.kind == IVM_PERIPH) |-> ({lookup_r.bankIdx, lookup_r.bankBit} == lookup_r.irqNum);
  endproperty
  a_bank_div: assert property (p_bank_div) else $error("bank index not irq div 32");

  property p_prio_div;
    @(posedge ref_clk) disable iff (!nrst)
    (lookup_r.kind == IVM_PERIPH) |-> (lookup_r.prioIdx == lookup_r.irqNum[7:2]);
  endproperty
  a_prio_div: assert property (p_prio_div) else $error("priority index not irq div 4");

  property p_sw_only;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(swPend_r) |-> $past(swSetHit);
  endproperty
  a_sw_only: assert property (p_sw_only) else $error("software pend set without write");

  property p_sw_set_wins;
    @(posedge ref_clk) disable iff (!nrst)
    swSetHit |=> swPend_r;
  endproperty
  a_sw_set_wins: assert property (p_sw_set_wins) else $error("software pend lost");

  property p_vec_offset;
    @(posedge ref_clk) disable iff (!nrst)
    (lookupReq && lookupVec == 8'h14) |=>
      (lookup_r.irqNum == 8'h04 && lookup_r.tableAddr == 32'h0000_0050 && lookup_r.prioIdx == 6'h01);
  endproperty
  a_vec_offset: assert property (p_vec_offset) else $error("vector 20 misplaced");

  property p_dma_pair;
    @(posedge ref_clk) disable iff (!nrst)
    (dmaDoneIn[3] || dmaDoneIn[19]) |=> irqLine_r[3];
  endproperty
  a_dma_pair: assert property (p_dma_pair) else $error("dma pair not merged");

  property p_pend_service;
    @(posedge ref_clk) disable iff (!nrst)
    (lookupReq && lookupVec == VEC_PEND_SERVICE) |=>
      (lookup_r.kind == IVM_CORE_EXC && lookup_r.tableAddr == 32'h0000_0038);
  endproperty
  a_pend_service: assert property (p_pend_service) else $error("vector 14 wrong");

  property p_sys_tick;
    @(posedge ref_clk) disable iff (!nrst)
    sysTickReq_r == $past(sysTickIn);
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("system tick not forwarded");

  property p_dma_err;
    @(posedge ref_clk) disable iff (!nrst)
    irqLine_r[DMA_ERR_IRQ] |-> ($past(dmaErrIn) != '0);
  endproperty
  a_dma_err: assert property (p_dma_err) else $error("error line without cause");

  property p_reserved;
    @(posedge ref_clk) disable iff (!nrst)
    (lookupReq && lookupVec == 8'h0D) |=> (lookup_r.kind == IVM_RESERVED && lookup_r.valid);
  endproperty
  a_reserved: assert property (p_reserved) else $error("vector 13 not reserved");

endmodule
`default_nettype wire

// file: verification/ivm_ctrl_model.sv
// Model of the nested interrupt controller's pend-bank writes.
// Assumes the bench calls pend() and one ref_clk drives both sides.
`timescale 1ns/10ps
`default_nettype none
module ivm_ctrl_model
  import ivm_pkg::*;
(
  input wire logic ref_clk,
  output var ivm_pend_wr_t pendWr
);
  initial pendWr = '0;
  // ==========================================================
  // software pend by writes
  // One-cycle strobe, then idle so no write repeats by accident
  task automatic pend(input logic s, input logic c, input logic [2:0] b,
                      input logic [31:0] m);
    @(posedge ref_clk);
    #2;
    pendWr = '{setWr: s, clrWr: c, bankIdx: b, data: m};
    @(posedge ref_clk);
    #2;
    pendWr = '0;
  endtask
endmodule
`default_nettype wire

// file: verification/test_irq_vector_map.sv
// Self-checking bench for the interrupt vector map.
// Assumes one 40 MHz clock; outputs settle 2 ns after each rising edge.
`timescale 1ns/10ps
`default_nettype none
module test_irq_vector_map;
  import ivm_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] dmaDoneIn = '0;
  logic [15:0] dmaErrIn = '0;
  logic pendServiceIn = 1'b0;
  logic sysTickIn = 1'b0;
  logic lookupReq = 1'b0;
  logic [7:0] lookupVec = '0;
  ivm_pend_wr_t pendWr;
  logic [16:0] irqLine_r;
  logic swPend_r;
  logic pendServiceReq_r;
  logic sysTickReq_r;
  ivm_lookup_t lookup_r;
  int errTotal = 0;
  int testsRun = 0;
  int cycles = 0;
  int vecs[11] = '{0, 1, 2, 7, 13, 14, 15, 16, 20, 32, 110};
  ivm_vector_map dut (.ref_clk(ref_clk), .nrst(nrst), .dmaDoneIn(dmaDoneIn),
    .dmaErrIn(dmaErrIn), .pendServiceIn(pendServiceIn), .sysTickIn(sysTickIn),
    .pendWr(pendWr), .lookupReq(lookupReq), .lookupVec(lookupVec),
    .irqLine_r(irqLine_r), .swPend_r(swPend_r), .pendServiceReq_r(pendServiceReq_r),
    .sysTickReq_r(sysTickReq_r), .lookup_r(lookup_r));
  ivm_ctrl_model ctrl (.ref_clk(ref_clk), .pendWr(pendWr));
  // ==========================================================
  // Clock and watchdog; the run needs about 45 cycles
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errTotal++;
      final_report();
    end
  end
  task automatic step();
    @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      errTotal++;
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Expected lookup answer, worked out from the vector numbering
  function automatic ivm_lookup_t exp_lk(input logic [7:0] v);
    logic [7:0] n;
    exp_lk = '0;
    n = v - 8'h10;
    exp_lk.valid = 1'b1;
    exp_lk.vector = v;
    exp_lk.tableAddr = 32'(v) * 4;
    exp_lk.kind = IVM_CORE_EXC;
    if (v == 8'h00) exp_lk.kind = IVM_STACK_PTR;
    if (v == 8'h01) exp_lk.kind = IVM_RESET_PC;
    if (v inside {7, 8, 9, 10, 13}) exp_lk.kind = IVM_RESERVED;
    if (v >= 8'h10) begin
      exp_lk.kind = IVM_PERIPH;
      exp_lk.irqNum = n;
      exp_lk.bankIdx = 3'(n / 32);
      exp_lk.bankBit = 5'(n % 32);
      exp_lk.prioIdx = 6'(n / 4);
      exp_lk.prioByte = 2'(n % 4);
    end
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_dma();
    for (int k = 0; k < 16; k++) begin
      dmaDoneIn = 32'h0000_0001 << (k + 16 * (k % 2));
      dmaErrIn = 16'h0001 << k;
      step();
      chk("irqLine", 64'({1'b1, 16'h0001 << k}), 64'(irqLine_r));
    end
    dmaDoneIn = '0;
    dmaErrIn = '0;
    step();
    chk("irqIdle", 64'h0, 64'(irqLine_r));
    $display("t_dma done");
  endtask
  task automatic t_exc();
    pendServiceIn = 1'b1;
    step();
    chk("pendSvc", 64'h2, 64'({pendServiceReq_r, sysTickReq_r}));
    pendServiceIn = 1'b0;
    sysTickIn = 1'b1;
    step();
    chk("system_tick_exception", 64'h1, 64'({pendServiceReq_r, sysTickReq_r}));
    sysTickIn = 1'b0;
    step();
    chk("excIdle", 64'h0, 64'({pendServiceReq_r, sysTickReq_r}));
    $display("t_exc done");
  endtask
  task automatic t_lookup();
    ivm_lookup_t e;
    foreach (vecs[i]) begin
      lookupReq = 1'b1;
      lookupVec = 8'(vecs[i]);
      e = exp_lk(8'(vecs[i]));
      step();
      // The 64-bit compare drops the top of the answer, so check valid and kind apart
      chk("lookupKind", 64'({e.valid, e.kind}), 64'({lookup_r.valid, lookup_r.kind}));
      chk("lookup", 64'(e), 64'(lookup_r));
    end
    lookupReq = 1'b0;
    step();
    chk("lookupIdle", 64'h0, 64'(lookup_r.valid));
    $display("t_lookup done");
  endtask
  task automatic t_pend();
    ctrl.pend(1'b1, 1'b0, 3'h2, 32'h4000_0000);
    chk("swSet", 64'h1, 64'(swPend_r));
    ctrl.pend(1'b0, 1'b1, 3'h1, 32'hFFFF_FFFF);
    chk("swOtherBank", 64'h1, 64'(swPend_r));
    ctrl.pend(1'b1, 1'b1, 3'h2, 32'h4000_0000);
    chk("swBoth", 64'h1, 64'(swPend_r));
    ctrl.pend(1'b0, 1'b1, 3'h2, 32'hBFFF_FFFF);
    chk("swOtherBit", 64'h1, 64'(swPend_r));
    ctrl.pend(1'b0, 1'b1, 3'h2, 32'h4000_0000);
    chk("swClr", 64'h0, 64'(swPend_r));
    $display("t_pend done");
  endtask
  // ==========================================================
  // Main sequence: reset for three cycles, then each scenario
  initial begin
    repeat (3) @(posedge ref_clk);
    #2;
    chk("resetLookup", 64'h0, 64'(lookup_r));
    nrst = 1'b1;
    t_dma();
    t_exc();
    t_lookup();
    t_pend();
    final_report();
  end
endmodule
`default_nettype wire
